// [core/rww_core.sv]
// Reset, sleep and wake-up sequencer with watchdog, behind an APB slave.
// Assumes pclk runs at 50 MHz; the reset pin and wake events are asynchronous.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
module rww_core #(
  parameter int HOLD_CYC = rww_pkg::RST_HOLD_CYC,
  parameter int LXT_CYC = rww_pkg::LXT_HOLD_CYC,
  parameter int WAKE_DLY_CYC = rww_pkg::WAKE_CYC,
  parameter int WDT_CYC = rww_pkg::WDT_TICK_CYC
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins and events
  input wire logic reset_pin_n,
  input wire logic port_change,
  input wire logic conversion_done,
  input wire logic conversion_busy,
  input wire logic converter_clock_tick,
  input wire logic low_voltage,
  // Core instructions, one-cycle pulses
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic global_irq_on_instr,
  input wire logic global_irq_off_instr,
  // Core controls
  output logic core_reset,
  output logic osc_run,
  output logic timers_run,
  output logic pc_load,
  output logic [10:0] program_counter,
  output logic ports_input,
  output logic timer_control_clear
);

  // Watchdog restarts from zero while the core is held in reset

  // ==========================================
  // Synchronisers
  logic [1:0] pin_s_r, chg_s_r, done_s_r, lv_s_r, busy_s_r, tad_s_r;
  logic tad_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s_r <= 2'b00;
      chg_s_r <= 2'b00;
      done_s_r <= 2'b00;
      lv_s_r <= 2'b00;
      busy_s_r <= 2'b00;
      tad_s_r <= 2'b00;
      tad_d_r <= 1'b0;
    end else begin
      pin_s_r <= {pin_s_r[0], reset_pin_n};
      chg_s_r <= {chg_s_r[0], port_change};
      done_s_r <= {done_s_r[0], conversion_done};
      lv_s_r <= {lv_s_r[0], low_voltage};
      busy_s_r <= {busy_s_r[0], conversion_busy};
      tad_s_r <= {tad_s_r[0], converter_clock_tick};
      tad_d_r <= tad_s_r[1];
    end
  end
  logic pin_low, tad_edge;
  assign pin_low = !pin_s_r[1];
  assign tad_edge = tad_s_r[1] && !tad_d_r;

  // ==========================================
  // Registers
  logic wdt_on_r, wdt_on_nxt;
  logic div_on_r, div_on_nxt;
  logic [2:0] div_sel_r, div_sel_nxt;
  logic pc_wake_en_r, pc_wake_en_nxt;
  logic adc_wake_en_r, adc_wake_en_nxt;
  logic lv_wake_en_r, lv_wake_en_nxt;
  logic lxt_r, lxt_nxt;
  logic xtal_r, xtal_nxt;
  logic gie_r, gie_nxt;
  logic to_r, to_nxt;
  logic pd_r, pd_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic wdt_clear, wdt_timeout;
  rww_pkg::rww_state_t st_r, st_nxt;

  // Watchdog time-out is a one-cycle pulse in this domain already; the
  // synchronised pin is what gates the hold counter.
  rww_wdt #(
    .TICK_CYC(WDT_CYC)
  ) u_wdt (
    .pclk(pclk),
    .presetn(presetn),
    .enable(wdt_on_r),
    .clear(wdt_clear),
    .div_on(div_on_r),
    .div_sel(div_sel_r),
    .timeout(wdt_timeout)
  );

  logic apb_wr, apb_rd;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  always_comb begin
    wdt_on_nxt = wdt_on_r;
    div_on_nxt = div_on_r;
    div_sel_nxt = div_sel_r;
    pc_wake_en_nxt = pc_wake_en_r;
    adc_wake_en_nxt = adc_wake_en_r;
    lv_wake_en_nxt = lv_wake_en_r;
    lxt_nxt = lxt_r;
    xtal_nxt = xtal_r;
    gie_nxt = gie_r;
    prdata_nxt = prdata_r;
    if (apb_wr) begin
      unique case (paddr)
        rww_pkg::A_WDT_CTRL: begin
          wdt_on_nxt = pwdata[rww_pkg::F_WDT_ON];
          div_on_nxt = pwdata[rww_pkg::F_DIV_ON];
          div_sel_nxt = pwdata[rww_pkg::F_DIV_SEL +: 3];
        end
        rww_pkg::A_WAKE_CTRL: begin
          pc_wake_en_nxt = pwdata[rww_pkg::F_PC_WAKE];
          adc_wake_en_nxt = pwdata[rww_pkg::F_ADC_WAKE];
          lv_wake_en_nxt = pwdata[rww_pkg::F_LV_WAKE];
        end
        rww_pkg::A_MODE: begin
          lxt_nxt = pwdata[0];
          xtal_nxt = pwdata[1];
        end
        default: begin
        end
      endcase
    end
    if (apb_rd) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        rww_pkg::A_WDT_CTRL: begin
          prdata_nxt[rww_pkg::F_WDT_ON] = wdt_on_r;
          prdata_nxt[rww_pkg::F_DIV_ON] = div_on_r;
          prdata_nxt[rww_pkg::F_DIV_SEL +: 3] = div_sel_r;
        end
        rww_pkg::A_WAKE_CTRL: begin
          prdata_nxt[2:0] = {pc_wake_en_r, adc_wake_en_r, lv_wake_en_r};
        end
        rww_pkg::A_STATUS: begin
          prdata_nxt[rww_pkg::F_TO] = to_r;
          prdata_nxt[rww_pkg::F_PD] = pd_r;
          prdata_nxt[rww_pkg::F_SLEEP] = (st_r == rww_pkg::RWW_SLEEP);
          prdata_nxt[rww_pkg::F_HOLD] = (st_r == rww_pkg::RWW_HOLD);
        end
        rww_pkg::A_MODE: begin
          prdata_nxt[1:0] = {xtal_r, lxt_r};
        end
        default: begin
        end
      endcase
    end
    // Interrupt enable state of the core, as last set by its instructions
    if (global_irq_on_instr) begin
      gie_nxt = 1'b1;
    end else if (global_irq_off_instr) begin
      gie_nxt = 1'b0;
    end
  end

  // ==========================================
  // Sequencer
  logic [rww_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [3:0] tad_cnt_r, tad_cnt_nxt;
  logic adc_wake_r, adc_wake_nxt;
  logic core_reset_nxt, osc_run_nxt, timers_run_nxt, pc_load_nxt, ports_in_nxt, tcw_clr_nxt;
  logic [10:0] pc_nxt;
  logic wdt_rst, pin_wake, evt_wake;
  logic [rww_pkg::CNT_W-1:0] hold_len, wake_len;

  assign wdt_rst = wdt_timeout && wdt_on_r;
  assign pin_wake = pin_low;
  assign evt_wake = (chg_s_r[1] && pc_wake_en_r) || (done_s_r[1] && adc_wake_en_r)
    || (lv_s_r[1] && lv_wake_en_r);
  // Clearing during the hold stops a stale count from firing just after release
  assign wdt_clear = watchdog_clear_instr || (sleep_instr && st_r == rww_pkg::RWW_RUN)
    || (st_r == rww_pkg::RWW_HOLD);
  assign hold_len = lxt_r ? rww_pkg::CNT_W'(LXT_CYC) : rww_pkg::CNT_W'(HOLD_CYC);
  // Crystal wakes need the start-up time before the settle count
  assign wake_len = lxt_r ? rww_pkg::CNT_W'(LXT_CYC)
    : (xtal_r ? rww_pkg::CNT_W'(WAKE_DLY_CYC) : rww_pkg::CNT_W'(1));

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    tad_cnt_nxt = tad_cnt_r;
    adc_wake_nxt = adc_wake_r;
    to_nxt = to_r;
    pd_nxt = pd_r;
    core_reset_nxt = 1'b0;
    osc_run_nxt = 1'b1;
    timers_run_nxt = 1'b1;
    pc_load_nxt = 1'b0;
    pc_nxt = program_counter;
    ports_in_nxt = 1'b0;
    tcw_clr_nxt = 1'b0;
    unique case (st_r)
      rww_pkg::RWW_HOLD: begin
        core_reset_nxt = 1'b1;
        ports_in_nxt = 1'b1;
        tcw_clr_nxt = 1'b1;
        pc_nxt = rww_pkg::PC_RESET;
        timers_run_nxt = 1'b0;
        if (pin_low) begin
          cnt_nxt = '0;
        end else if (cnt_r >= hold_len - rww_pkg::CNT_W'(1)) begin
          st_nxt = rww_pkg::RWW_RUN;
          cnt_nxt = '0;
          pc_load_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + rww_pkg::CNT_W'(1);
        end
      end
      rww_pkg::RWW_RUN: begin
        if (watchdog_clear_instr) begin
          to_nxt = 1'b1;
          pd_nxt = 1'b1;
        end
        if (pin_low) begin
          st_nxt = rww_pkg::RWW_HOLD;
          cnt_nxt = '0;
        end else if (wdt_rst) begin
          st_nxt = rww_pkg::RWW_HOLD;
          to_nxt = 1'b0;
          cnt_nxt = '0;
        end else if (sleep_instr) begin
          st_nxt = rww_pkg::RWW_SLEEP;
          to_nxt = 1'b1;
          pd_nxt = 1'b0;
          osc_run_nxt = busy_s_r[1];
          timers_run_nxt = busy_s_r[1];
        end
      end
      rww_pkg::RWW_SLEEP: begin
        osc_run_nxt = busy_s_r[1];
        timers_run_nxt = busy_s_r[1];
        if (pin_wake) begin
          st_nxt = rww_pkg::RWW_HOLD;
          to_nxt = 1'b1;
          pd_nxt = 1'b0;
          cnt_nxt = '0;
        end else if (wdt_rst) begin
          st_nxt = rww_pkg::RWW_HOLD;
          to_nxt = 1'b0;
          pd_nxt = 1'b0;
          cnt_nxt = '0;
        end else if (evt_wake) begin
          st_nxt = rww_pkg::RWW_WAKE;
          to_nxt = 1'b1;
          pd_nxt = 1'b0;
          cnt_nxt = '0;
          tad_cnt_nxt = 4'h0;
          adc_wake_nxt = done_s_r[1] && adc_wake_en_r && !(chg_s_r[1] && pc_wake_en_r);
        end
      end
      rww_pkg::RWW_WAKE: begin
        // Conversion wakes first wait out the converter periods
        osc_run_nxt = 1'b1;
        timers_run_nxt = 1'b0;
        if (pin_low) begin
          st_nxt = rww_pkg::RWW_HOLD;
          cnt_nxt = '0;
        end else if (adc_wake_r && tad_cnt_r != 4'(rww_pkg::ADC_WAKE_TAD)) begin
          if (tad_edge) begin
            tad_cnt_nxt = tad_cnt_r + 4'h1;
          end
        end else if (cnt_r >= wake_len - rww_pkg::CNT_W'(1)) begin
          st_nxt = rww_pkg::RWW_SETTLE;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + rww_pkg::CNT_W'(1);
        end
      end
      rww_pkg::RWW_SETTLE: begin
        timers_run_nxt = 1'b0;
        if (pin_low) begin
          st_nxt = rww_pkg::RWW_HOLD;
          cnt_nxt = '0;
        end else if (lxt_r || cnt_r == rww_pkg::CNT_W'(rww_pkg::OSC_SETTLE_CLKS - 1)) begin
          st_nxt = rww_pkg::RWW_RUN;
          cnt_nxt = '0;
          pc_load_nxt = gie_r;
          pc_nxt = gie_r ? rww_pkg::PC_IRQ_VEC : program_counter;
        end else begin
          cnt_nxt = cnt_r + rww_pkg::CNT_W'(1);
        end
      end
      default: begin
        st_nxt = rww_pkg::RWW_HOLD;
      end
    endcase
  end

  // software is expected to switch the watchdog off before event sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= rww_pkg::RWW_HOLD;
      cnt_r <= '0;
      tad_cnt_r <= 4'h0;
      adc_wake_r <= 1'b0;
      to_r <= 1'b1;
      pd_r <= 1'b1;
      wdt_on_r <= 1'b0;
      div_on_r <= 1'b0;
      div_sel_r <= 3'h0;
      pc_wake_en_r <= 1'b0;
      adc_wake_en_r <= 1'b0;
      lv_wake_en_r <= 1'b0;
      lxt_r <= 1'b0;
      xtal_r <= 1'b0;
      gie_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      core_reset <= 1'b1;
      osc_run <= 1'b1;
      timers_run <= 1'b0;
      pc_load <= 1'b0;
      program_counter <= rww_pkg::PC_RESET;
      ports_input <= 1'b1;
      timer_control_clear <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tad_cnt_r <= tad_cnt_nxt;
      adc_wake_r <= adc_wake_nxt;
      to_r <= to_nxt;
      pd_r <= pd_nxt;
      wdt_on_r <= wdt_on_nxt;
      div_on_r <= div_on_nxt;
      div_sel_r <= div_sel_nxt;
      pc_wake_en_r <= pc_wake_en_nxt;
      adc_wake_en_r <= adc_wake_en_nxt;
      lv_wake_en_r <= lv_wake_en_nxt;
      lxt_r <= lxt_nxt;
      xtal_r <= xtal_nxt;
      gie_r <= gie_nxt;
      prdata_r <= prdata_nxt;
      core_reset <= core_reset_nxt;
      osc_run <= osc_run_nxt;
      timers_run <= timers_run_nxt;
      pc_load <= pc_load_nxt;
      program_counter <= pc_nxt;
      ports_input <= ports_in_nxt;
      timer_control_clear <= tcw_clr_nxt;
    end
  end

  // Zero-wait slave: answers in the first access cycle
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

endmodule

// [core/rww_pkg.sv]
// Constants for the reset, sleep, wake-up and watchdog block.
// Assumes a 50 MHz system clock; times are given in their own unit.
package rww_pkg;

  // ==========================================
  // Clock and timing
  localparam int CLK_HZ = 50000000;
  localparam int RST_HOLD_US = 18000;
  localparam int LXT_HOLD_US = 500000;
  localparam int WAKE_US = 2000;
  localparam int OSC_SETTLE_CLKS = 32;
  localparam int ADC_WAKE_TAD = 15;
  localparam int WDT_PERIOD_US = 18000;
  localparam int RST_HOLD_CYC = RST_HOLD_US * (CLK_HZ / 1000000);
  localparam int LXT_HOLD_CYC = LXT_HOLD_US * (CLK_HZ / 1000000);
  localparam int WAKE_CYC = WAKE_US * (CLK_HZ / 1000000);
  localparam int WDT_TICK_CYC = WDT_PERIOD_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 25;

  // ==========================================
  // Addresses, vectors, reset values
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [10:0] PC_IRQ_VEC = 11'h008;
  localparam int TCW_KEEP_BIT = 6;
  localparam logic [7:0] TCW_RESET = 8'h00;
  localparam int DIV_W = 8;

  // ==========================================
  // APB register map, byte addresses
  localparam logic [7:0] A_WDT_CTRL = 8'h00;
  localparam logic [7:0] A_WAKE_CTRL = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_MODE = 8'h0C;
  // Watchdog control field positions
  localparam int F_WDT_ON = 7;
  localparam int F_DIV_ON = 5;
  localparam int F_DIV_SEL = 2;
  // Wake control field positions
  localparam int F_PC_WAKE = 2;
  localparam int F_ADC_WAKE = 1;
  localparam int F_LV_WAKE = 0;
  // Status field positions
  localparam int F_TO = 1;
  localparam int F_PD = 0;
  localparam int F_SLEEP = 2;
  localparam int F_HOLD = 3;

  typedef enum logic [2:0] {
    RWW_HOLD = 3'b000,
    RWW_RUN = 3'b001,
    RWW_SLEEP = 3'b010,
    RWW_WAKE = 3'b011,
    RWW_SETTLE = 3'b100
  } rww_state_t;

endpackage

// [core/rww_wdt.sv]
// Watchdog with its own 8-bit prescaler, one tick counter and a time-out flag.
// Assumes the caller holds clear high through the reset hold and supplies a clock that is never gated.
`timescale 1ns/1ns
module rww_wdt #(
  parameter int TICK_CYC = rww_pkg::WDT_TICK_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic enable,
  input wire logic clear,
  input wire logic div_on,
  input wire logic [2:0] div_sel,
  // Event
  output logic timeout
);

  logic [rww_pkg::CNT_W-1:0] base_r, base_nxt;
  logic [rww_pkg::DIV_W-1:0] div_r, div_nxt;
  logic timeout_r, timeout_nxt;
  logic [rww_pkg::DIV_W-1:0] div_top;

  assign timeout = timeout_r;

  // ==========================================
  // Counting
  always_comb begin
    // Select field: 000 gives 1:2 up to 111 giving 1:256
    div_top = div_on ? rww_pkg::DIV_W'((9'h002 << div_sel) - 9'h001) : 8'h00;
    base_nxt = base_r;
    div_nxt = div_r;
    timeout_nxt = 1'b0;
    if (clear || !enable) begin
      base_nxt = '0;
      div_nxt = '0;
    end else if (base_r == rww_pkg::CNT_W'(TICK_CYC - 1)) begin
      base_nxt = '0;
      if (div_r == div_top) begin
        div_nxt = '0;
        timeout_nxt = 1'b1;
      end else begin
        div_nxt = div_r + 8'h01;
      end
    end else begin
      base_nxt = base_r + rww_pkg::CNT_W'(1);
    end
  end

  // Free-running: keeps counting while the core clock is stopped in sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_r <= '0;
      div_r <= '0;
      timeout_r <= 1'b0;
    end else begin
      base_r <= base_nxt;
      div_r <= div_nxt;
      timeout_r <= timeout_nxt;
    end
  end

endmodule

// [sim/reset_wakeup_watchdog_tb.sv]
// Bench for the reset, sleep and wake sequencer with its watchdog.
// Assumes short hold and watchdog counts set here; flags modelled as ints.
`timescale 1ns/1ns
module reset_wakeup_watchdog_tb;
  localparam int HC = 50;
  localparam int LC = 80;
  localparam int WC = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic reset_pin_n, conversion_busy, converter_clock_tick, go, core_reset, osc_run;
  logic timers_run, pc_load, ports_input, timer_control_clear, seen;
  logic [2:0] ev;
  logic [1:0] op;
  logic [10:0] program_counter, lpc;
  wire sleep_instr, watchdog_clear_instr, global_irq_on_instr, global_irq_off_instr;
  int miscompares, total_checks, n, exp_t, exp_p, gie;
  int per[3] = '{WC, 2 * WC, 256 * WC};
  logic [7:0] cv[3] = '{8'h80, 8'hA0, 8'hBC};
  int lo[3] = '{32, 78, 78};
  logic [31:0] md[3] = '{32'h0, 32'h2, 32'h1};

  rww_cpu cpu (.go, .op, .sleep_instr, .watchdog_clear_instr, .global_irq_on_instr, .global_irq_off_instr);
  rww_core #(.HOLD_CYC(HC), .LXT_CYC(LC), .WAKE_DLY_CYC(20), .WDT_CYC(WC)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n, .port_change(ev[2]),
    .conversion_done(ev[1]), .conversion_busy, .converter_clock_tick, .low_voltage(ev[0]), .sleep_instr,
    .watchdog_clear_instr, .global_irq_on_instr, .global_irq_off_instr, .core_reset, .osc_run, .timers_run,
    .pc_load, .program_counter, .ports_input, .timer_control_clear);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) converter_clock_tick <= ~converter_clock_tick;
  always @(posedge pclk) begin
    if (pc_load === 1'b1) begin
      seen <= 1'b1;
      lpc <= program_counter;
    end
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task chk(input logic [31:0] e, input logic [31:0] g, input string w);
    total_checks++;
    if (e !== g) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  // Access phase lasts until pready; nothing released before that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task ins(input logic [1:0] k);
    @(posedge pclk);
    go <= 1'b1;
    op <= k;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  function automatic logic hit(input int k);
    case (k)
      0: return core_reset === 1'b1;
      1: return timers_run === 1'b1 && core_reset === 1'b0;
      default: return osc_run === 1'b0;
    endcase
  endfunction
  task waitc(input int k);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (!hit(k) && n < 3000);
    if (n >= 3000) chk(1, 0, "wait");
  endtask
  task flags();
    apb(1'b0, rww_pkg::A_STATUS, 32'h0);
    chk(exp_t, rd[rww_pkg::F_TO], "flag_t");
    chk(exp_p, rd[rww_pkg::F_PD], "flag_p");
  endtask
  task pin_rst();
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    waitc(0);
    repeat (3) @(posedge pclk);
    reset_pin_n <= 1'b1;
    waitc(1);
  endtask
  task summarize();
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #1000000;
    miscompares++;
    summarize();
  end

  // ==========================================
  // Scenarios
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev, conversion_busy, go, op} = '0;
    {reset_pin_n, converter_clock_tick, seen, seed} = {3'b100, 32'h0B4B7DCE};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    waitc(1);
    chk(1, n >= HC && n <= HC + 12, "hold");
    chk(11'h000, program_counter, "pc");
    exp_t = 1;
    exp_p = 1;
    flags();
    apb(1'b0, 8'h10, 32'h0);
    chk(0, rd, "unmapped");
    seed = xs(seed);
    apb(1'b1, rww_pkg::A_WDT_CTRL, seed & 32'h3C);
    apb(1'b0, rww_pkg::A_WDT_CTRL, 32'h0);
    chk(seed & 32'h3C, rd, "wdt_ctrl");
    // Watchdog time-out in run with no prescaler, then at 1:2 and 1:256
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, rww_pkg::A_WDT_CTRL, {24'h0, cv[i]});
      waitc(0);
      chk(1, n >= per[i] - 1 && n <= per[i] + 8, "wdt_period");
      exp_t = 0;
      waitc(1);
      flags();
      apb(1'b1, rww_pkg::A_WDT_CTRL, 32'h0);
    end
    apb(1'b1, rww_pkg::A_MODE, 32'h1);
    pin_rst();
    chk(1, n >= LC && n <= LC + 12, "lxt_hold");
    flags();
    apb(1'b1, rww_pkg::A_MODE, 32'h0);
    // Regular clears keep an enabled watchdog quiet
    apb(1'b1, rww_pkg::A_WDT_CTRL, 32'h80);
    repeat (5) begin
      repeat (WC - 4) @(posedge pclk);
      ins(2'h1);
      chk(0, core_reset, "wdt_cleared");
    end
    apb(1'b1, rww_pkg::A_WDT_CTRL, 32'h0);
    exp_t = 1;
    flags();
    ins(2'h0);
    waitc(2);
    exp_p = 0;
    flags();
    pin_rst();
    flags();
    chk(11'h000, program_counter, "pc_pin");
    apb(1'b1, rww_pkg::A_WDT_CTRL, 32'h80);
    ins(2'h0);
    waitc(0);
    exp_t = 0;
    waitc(1);
    flags();
    apb(1'b1, rww_pkg::A_WDT_CTRL, 32'h0);
    // Event wakes: port change RC, conversion crystal, low voltage LOW_CRYSTAL_MODE
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      gie = seed[0];
      ins(gie ? 2'h2 : 2'h3);
      apb(1'b1, rww_pkg::A_MODE, md[k]);
      apb(1'b1, rww_pkg::A_WAKE_CTRL, 32'h1 << (2 - k));
      ins(2'h0);
      waitc(2);
      @(posedge pclk);
      ev <= 3'h1 << ((4 - k) % 3);
      repeat (40) @(posedge pclk);
      chk(0, osc_run, "masked_wake");
      ev <= 3'h0;
      repeat (4) @(posedge pclk);
      seen <= 1'b0;
      ev <= 3'h1 << (2 - k);
      waitc(1);
      chk(1, n >= lo[k] && n <= lo[k] + 14, "wake_time");
      ev <= 3'h0;
      exp_t = 1;
      exp_p = 0;
      flags();
      chk(gie, seen, "vector_load");
      if (gie) chk(11'h008, lpc, "vector");
    end
    apb(1'b1, rww_pkg::A_MODE, 32'h0);
    apb(1'b1, rww_pkg::A_WAKE_CTRL, 32'h0);
    conversion_busy <= 1'b1;
    repeat (4) @(posedge pclk);
    ins(2'h0);
    repeat (6) @(posedge pclk);
    chk(2'b11, {osc_run, timers_run}, "busy_sleep");
    conversion_busy <= 1'b0;
    pin_rst();
    flags();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    waitc(1);
    exp_p = 1;
    flags();
    summarize();
  end
endmodule

// [sim/rww_asserts.sv]
// Port checker for the reset, sleep and wake sequencer.
// Assumes one clock pclk and an async active-low presetn.
`timescale 1ns/1ns
module rww_asserts #(
  parameter int HOLD_CYC = rww_pkg::RST_HOLD_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Causes
  input wire logic reset_pin_n,
  input wire logic conversion_busy,
  input wire logic sleep_instr,
  // Effects
  input wire logic core_reset,
  input wire logic osc_run,
  input wire logic timers_run,
  input wire logic pc_load,
  input wire logic [10:0] program_counter,
  input wire logic ports_input,
  input wire logic timer_control_clear
);
  // ==========================================
  // Hold length, counted as cycles with reset high
  logic [15:0] hold_r;
  logic [15:0] hold_nxt;
  always_comb hold_nxt = core_reset ? hold_r + 16'h0001 : 16'h0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_r <= 16'h0000;
    else hold_r <= hold_nxt;
  end
  // ==========================================
  // Properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pin_low;
    !reset_pin_n [*2];
  endsequence
  sequence s_idle_sleep;
    sleep_instr && timers_run && !conversion_busy;
  endsequence
  sequence s_busy_sleep;
    conversion_busy [*4] ##0 (sleep_instr && timers_run);
  endsequence
  chk_hold_ports: assert property (core_reset |-> ports_input && timer_control_clear)
    else $error("pins or control word not held in reset");
  chk_pc_zero: assert property (core_reset |-> program_counter == rww_pkg::PC_RESET)
    else $error("program counter not zero in reset");
  chk_reset_osc: assert property (core_reset |-> osc_run && !timers_run)
    else $error("oscillator stopped or timers running in reset");
  chk_pin_reset: assert property (s_pin_low |-> ##[0:4] core_reset)
    else $error("low reset pin gave no reset");
  chk_hold_len: assert property ($fell(core_reset) |-> hold_r >= HOLD_CYC - 1)
    else $error("reset hold too short");
  chk_sleep_stop: assert property (s_idle_sleep |-> ##[1:3] (!osc_run && !timers_run))
    else $error("sleep did not stop clocks");
  chk_busy_run: assert property (s_busy_sleep |=> (osc_run && timers_run) [*3])
    else $error("clocks stopped during conversion");
  chk_pc_vector: assert property (pc_load |->
    program_counter == rww_pkg::PC_RESET || program_counter == rww_pkg::PC_IRQ_VEC)
    else $error("program counter loaded with a bad address");
endmodule

bind rww_core rww_asserts #(.HOLD_CYC(HOLD_CYC)) u_rww_asserts (.pclk, .presetn, .reset_pin_n,
  .conversion_busy, .sleep_instr, .core_reset, .osc_run, .timers_run, .pc_load, .program_counter,
  .ports_input, .timer_control_clear);

// [sim/rww_cpu.sv]
// Processor core stand-in: turns a bench command into one instruction pulse.
// Assumes go is high for exactly one pclk cycle.
`timescale 1ns/1ns
module rww_cpu (
  // Command
  input wire logic go,
  input wire logic [1:0] op,
  // Instructions
  output logic sleep_instr,
  output logic watchdog_clear_instr,
  output logic global_irq_on_instr,
  output logic global_irq_off_instr
);
  assign sleep_instr = go && op == 2'h0;
  assign watchdog_clear_instr = go && op == 2'h1;
  assign global_irq_on_instr = go && op == 2'h2;
  assign global_irq_off_instr = go && op == 2'h3;
endmodule
